/* rtl/sync_serial_status_pkg.sv */
package sync_serial_status_pkg;
	// Bus and data widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int WORD_W = 32;
	localparam int SYNC_W = 16;
	localparam int CNT_W = 16;
	localparam int LEN_W = 5;
	localparam int FLAG_W = 12;
	localparam int PIN_N = 3;
	localparam int SYNC_STAGES = 3;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFF_RX_HOLD = 8'h20;
	localparam logic [ADDR_W-1:0] OFF_TX_HOLD = 8'h24;
	localparam logic [ADDR_W-1:0] OFF_RX_SYNC_HOLD = 8'h30;
	localparam logic [ADDR_W-1:0] OFF_TX_SYNC_HOLD = 8'h34;
	localparam logic [ADDR_W-1:0] OFF_CMP_ZERO = 8'h38;
	localparam logic [ADDR_W-1:0] OFF_CMP_ONE = 8'h3C;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h40;
	localparam logic [ADDR_W-1:0] OFF_IRQ_SET = 8'h44;
	localparam logic [ADDR_W-1:0] OFF_IRQ_CLR = 8'h48;
	localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h4C;

	// Status bit positions
	localparam int ST_TX_FREE = 0;
	localparam int ST_TX_ALL_SENT = 1;
	localparam int ST_TX_DMA_DONE = 2;
	localparam int ST_TX_BUF_EMPTY = 3;
	localparam int ST_RX_AVAIL = 4;
	localparam int ST_RX_OVERRUN = 5;
	localparam int ST_RX_DMA_DONE = 6;
	localparam int ST_RX_BUF_FULL = 7;
	localparam int ST_CMP_ZERO = 8;
	localparam int ST_CMP_ONE = 9;
	localparam int ST_TX_SYNC = 10;
	localparam int ST_RX_SYNC = 11;
	localparam int ST_TX_EN = 16;
	localparam int ST_RX_EN = 17;

	// Flags that clear on a status read
	localparam logic [FLAG_W-1:0] READ_CLEAR_MASK = 12'hF20;

	// Frame-sync edge selector encodings
	localparam logic EDGE_RISE = 1'h0;
	localparam logic EDGE_FALL = 1'h1;

	// Reset values and word length limits
	localparam logic [FLAG_W-1:0] MASK_RESET = 12'h000;
	localparam logic [SYNC_W-1:0] SYNC_RESET = 16'h0000;
	localparam logic [WORD_W-1:0] WORD_RESET = 32'h0000_0000;
	localparam logic [LEN_W-1:0] LEN_MAX = 5'h1F;
	localparam logic [LEN_W-1:0] LEN_FORBIDDEN = 5'h00;
endpackage : sync_serial_status_pkg

/* rtl/sync_serial_status_data_regs.sv */
// Function
// - Edge selector: 0 rising, 1 falling
// - Data words right aligned at bit zero
// - Holding-free flag low while word waits
// - All-sent only after shifter finished last word
// - DMA done sets at zero, write clears
// - Buffer flags: both DMA counts zero
// - Receive-available set when word loaded
// - Overrun on unread word, clear on status read
// - Receive DMA done: zero sets, write clears
// - Compare zero flag, status read clears
// - Compare one flag, status read clears
// - Transmit sync flag, status read clears
// - Receive sync flag, status read clears
// - Status shows both direction enables
// - Enable register writes ones only
// - Word has length field plus one bits
// - Sync word shifted out during frame sync
`timescale 1ns/1ps
module sync_serial_status_data_regs (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [sync_serial_status_pkg::ADDR_W-1:0] i_paddr,
	input wire logic [sync_serial_status_pkg::DATA_W-1:0] i_pwdata,
	output logic [sync_serial_status_pkg::DATA_W-1:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_link_clk,
	input wire logic i_tx_frame_sync,
	input wire logic i_rx_frame_sync,
	output logic o_sync_data_bit,
	output logic o_sync_data_drive,
	input wire logic [sync_serial_status_pkg::LEN_W-1:0] i_word_length_field,
	input wire logic i_sync_edge_select,
	input wire logic i_rx_sync_edge_select,
	input wire logic i_sync_data_enable,
	input wire logic i_tx_enabled_state,
	input wire logic i_rx_enabled_state,
	input wire logic i_tx_shift_ready,
	input wire logic i_tx_shift_busy,
	output logic [sync_serial_status_pkg::WORD_W-1:0] o_tx_word,
	output logic o_tx_word_load,
	input wire logic i_rx_word_load,
	input wire logic [sync_serial_status_pkg::WORD_W-1:0] i_rx_shift_word,
	input wire logic i_rx_sync_load,
	input wire logic [sync_serial_status_pkg::SYNC_W-1:0] i_rx_sync_shift,
	input wire logic [sync_serial_status_pkg::CNT_W-1:0] i_tx_dma_count,
	input wire logic [sync_serial_status_pkg::CNT_W-1:0] i_tx_dma_next_count,
	input wire logic i_tx_dma_count_wr,
	input wire logic [sync_serial_status_pkg::CNT_W-1:0] i_rx_dma_count,
	input wire logic [sync_serial_status_pkg::CNT_W-1:0] i_rx_dma_next_count,
	input wire logic i_rx_dma_count_wr,
	output logic o_irq
);
	import sync_serial_status_pkg::*;

	logic setup_ph;
	logic access_ph;
	logic wr_en;
	logic rd_en;
	logic [DATA_W-1:0] rd_val;
	logic rd_err;
	logic [DATA_W-1:0] prdata_r;
	logic err_r;
	logic [FLAG_W-1:0] status_vec;
	logic [DATA_W-1:0] status_word;
	logic [FLAG_W-1:0] imr_r;
	logic irq_r;
	logic [WORD_W-1:0] thr_r;
	logic tx_full_r;
	logic tx_move;
	logic [WORD_W-1:0] tx_word_r;
	logic tx_load_r;
	logic [WORD_W-1:0] rhr_r;
	logic rx_avail_r;
	logic rx_stale_r;
	logic rhr_rd;
	logic rx_clear;
	logic [SYNC_W-1:0] rshr_r;
	logic [SYNC_W-1:0] tshr_r;
	logic [SYNC_W-1:0] cmp0_r;
	logic [SYNC_W-1:0] cmp1_r;
	logic [FLAG_W-1:0] sticky_r;
	logic [FLAG_W-1:0] sticky_set;
	logic [FLAG_W-1:0] sticky_clr;
	logic [CNT_W-1:0] tx_cnt_prev_r;
	logic [CNT_W-1:0] rx_cnt_prev_r;
	logic tx_reached;
	logic rx_reached;
	logic tx_done_r;
	logic rx_done_r;
	logic [LEN_W-1:0] shr_amt;
	logic [WORD_W-1:0] word_mask;
	logic len_ok;
	logic [PIN_N-1:0] pin_in;
	logic [PIN_N-1:0] pin_lvl_r;
	logic [PIN_N-1:0] pin_prev_r;
	logic link_fall;
	logic tx_fs_rise;
	logic tx_fs_fall;
	logic rx_fs_rise;
	logic rx_fs_fall;
	logic tx_sync_evt;
	logic rx_sync_evt;
	logic tx_fs_active;
	logic [SYNC_W-1:0] sync_shift_r;

	assign setup_ph = i_psel & ~i_penable;
	assign access_ph = i_psel & i_penable;
	assign wr_en = access_ph & i_pwrite & ~err_r;
	assign rd_en = access_ph & ~i_pwrite & ~err_r;
	// Zero wait states: read data is captured in the setup cycle
	assign o_pready = access_ph;
	assign o_pslverr = access_ph & err_r;
	assign o_prdata = prdata_r;

	// Word length mask derived from the length field
	assign shr_amt = LEN_MAX - i_word_length_field;
	assign word_mask = WORD_RESET - 32'h0000_0001 >> shr_amt;
	assign len_ok = i_word_length_field != LEN_FORBIDDEN;

	// Pin synchronisers; a level counts once stages two and three agree
	assign pin_in = {i_rx_frame_sync, i_tx_frame_sync, i_link_clk};
	genvar gi;
	generate
		for (gi = 0; gi < PIN_N; gi++)
		begin : g_pin
			logic [SYNC_STAGES-1:0] stg_r;
			always_ff @(posedge i_clk_sys)
			begin
				if (!i_rst_n)
				begin
					stg_r <= '0;
					pin_lvl_r[gi] <= 1'b0;
					pin_prev_r[gi] <= 1'b0;
				end
				else
				begin
					stg_r <= {stg_r[SYNC_STAGES-2:0], pin_in[gi]};
					if (stg_r[1] == stg_r[2])
						pin_lvl_r[gi] <= stg_r[2];
					pin_prev_r[gi] <= pin_lvl_r[gi];
				end
			end
		end
	endgenerate

	assign link_fall = ~pin_lvl_r[0] & pin_prev_r[0];
	assign tx_fs_rise = pin_lvl_r[1] & ~pin_prev_r[1];
	assign tx_fs_fall = ~pin_lvl_r[1] & pin_prev_r[1];
	assign rx_fs_rise = pin_lvl_r[2] & ~pin_prev_r[2];
	assign rx_fs_fall = ~pin_lvl_r[2] & pin_prev_r[2];
	assign tx_sync_evt = (i_sync_edge_select == EDGE_RISE) ? tx_fs_rise : tx_fs_fall;
	assign rx_sync_evt = (i_rx_sync_edge_select == EDGE_RISE) ? rx_fs_rise : rx_fs_fall;
	// Frame sync is active in the level that follows the selected edge
	assign tx_fs_active = pin_lvl_r[1] ^ i_sync_edge_select;

	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rst_n)
			sync_shift_r <= SYNC_RESET;
		else if (tx_sync_evt)
			sync_shift_r <= tshr_r;
		else if (link_fall & tx_fs_active & i_sync_data_enable)
			sync_shift_r <= {1'b0, sync_shift_r[SYNC_W-1:1]};
	end
	assign o_sync_data_bit = sync_shift_r[0];
	assign o_sync_data_drive = tx_fs_active & i_sync_data_enable;

	// Register read mux, unmapped addresses answer with an error
	always_comb
	begin
		rd_val = '0;
		rd_err = 1'b0;
		if (i_paddr == OFF_RX_HOLD)
			rd_val = rhr_r;
		else if (i_paddr == OFF_TX_HOLD)
			rd_val = '0;
		else if (i_paddr == OFF_RX_SYNC_HOLD)
			rd_val = {16'h0000, rshr_r};
		else if (i_paddr == OFF_TX_SYNC_HOLD)
			rd_val = {16'h0000, tshr_r};
		else if (i_paddr == OFF_CMP_ZERO)
			rd_val = {16'h0000, cmp0_r};
		else if (i_paddr == OFF_CMP_ONE)
			rd_val = {16'h0000, cmp1_r};
		else if (i_paddr == OFF_STATUS)
			rd_val = status_word;
		else if (i_paddr == OFF_IRQ_SET || i_paddr == OFF_IRQ_CLR)
			rd_val = '0;
		else if (i_paddr == OFF_IRQ_MASK)
			rd_val = {20'h00000, imr_r};
		else
			rd_err = 1'b1;
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rst_n)
		begin
			prdata_r <= '0;
			err_r <= 1'b0;
		end
		else if (setup_ph)
		begin
			prdata_r <= i_pwrite ? '0 : rd_val;
			err_r <= rd_err;
		end
	end

	// enables shown beside the event flags
	assign status_word = {14'h0000, i_rx_enabled_state, i_tx_enabled_state, 4'h0, status_vec};

	// holding-free is the inverse of a waiting word
	assign status_vec[ST_TX_FREE] = ~tx_full_r;
	// nothing waiting, nothing handed over, shifter idle
	assign status_vec[ST_TX_ALL_SENT] = ~tx_full_r & ~tx_load_r & ~i_tx_shift_busy;
	assign status_vec[ST_TX_DMA_DONE] = tx_done_r;
	// both counts of a direction at zero
	assign status_vec[ST_TX_BUF_EMPTY] = (i_tx_dma_count == '0) && (i_tx_dma_next_count == '0);
	assign status_vec[ST_RX_AVAIL] = rx_avail_r;
	assign status_vec[ST_RX_OVERRUN] = sticky_r[ST_RX_OVERRUN];
	assign status_vec[ST_RX_DMA_DONE] = rx_done_r;
	assign status_vec[ST_RX_BUF_FULL] = (i_rx_dma_count == '0) && (i_rx_dma_next_count == '0);
	assign status_vec[ST_RX_SYNC:ST_CMP_ZERO] = sticky_r[ST_RX_SYNC:ST_CMP_ZERO];

	// Transmit holding; a new write overwrites a word not yet moved
	assign tx_move = tx_full_r & i_tx_shift_ready & i_tx_enabled_state & len_ok;
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rst_n)
		begin
			thr_r <= WORD_RESET;
			tx_full_r <= 1'b0;
		end
		else
		begin
			if (wr_en && i_paddr == OFF_TX_HOLD)
				thr_r <= i_pwdata;
			// write marks the holding register occupied
			tx_full_r <= (wr_en && i_paddr == OFF_TX_HOLD) | (tx_full_r & ~tx_move);
		end
	end

	// a forbidden length never hands a word to the shifter
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rst_n)
		begin
			tx_word_r <= WORD_RESET;
			tx_load_r <= 1'b0;
		end
		else
		begin
			tx_load_r <= tx_move;
			// only the low length-plus-one bits travel
			if (tx_move)
				tx_word_r <= thr_r & word_mask;
		end
	end
	assign o_tx_word = tx_word_r;
	assign o_tx_word_load = tx_load_r;

	// A word loaded during the read's setup cycle was not seen, so it stays
	assign rhr_rd = rd_en && i_paddr == OFF_RX_HOLD;
	assign rx_clear = rhr_rd & ~rx_stale_r;
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rst_n)
		begin
			rhr_r <= WORD_RESET;
			rx_avail_r <= 1'b0;
			rx_stale_r <= 1'b0;
		end
		else
		begin
			if (i_rx_word_load)
				rhr_r <= i_rx_shift_word & word_mask;
			// load sets, read clears, load wins
			rx_avail_r <= i_rx_word_load | (rx_avail_r & ~rx_clear);
			if (setup_ph)
				rx_stale_r <= i_rx_word_load;
		end
	end

	// Sync holding and compare values
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rst_n)
		begin
			rshr_r <= SYNC_RESET;
			tshr_r <= SYNC_RESET;
			cmp0_r <= SYNC_RESET;
			cmp1_r <= SYNC_RESET;
		end
		else
		begin
			if (i_rx_sync_load)
				rshr_r <= i_rx_sync_shift;
			if (wr_en && i_paddr == OFF_TX_SYNC_HOLD)
				tshr_r <= i_pwdata[SYNC_W-1:0];
			if (wr_en && i_paddr == OFF_CMP_ZERO)
				cmp0_r <= i_pwdata[SYNC_W-1:0];
			if (wr_en && i_paddr == OFF_CMP_ONE)
				cmp1_r <= i_pwdata[SYNC_W-1:0];
		end
	end

	// Read-clear flags; only bits seen by the read are cleared, so a late event survives
	always_comb
	begin
		sticky_set = '0;
		// overrun when an unread word is replaced
		sticky_set[ST_RX_OVERRUN] = i_rx_word_load & rx_avail_r & ~rx_clear;
		sticky_set[ST_CMP_ZERO] = i_rx_sync_load && i_rx_sync_shift == cmp0_r;
		sticky_set[ST_CMP_ONE] = i_rx_sync_load && i_rx_sync_shift == cmp1_r;
		sticky_set[ST_TX_SYNC] = tx_sync_evt;
		sticky_set[ST_RX_SYNC] = rx_sync_evt;
		sticky_clr = '0;
		if (rd_en && i_paddr == OFF_STATUS)
			sticky_clr = prdata_r[FLAG_W-1:0] & READ_CLEAR_MASK;
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rst_n)
			sticky_r <= '0;
		else
			sticky_r <= sticky_set | (sticky_r & ~sticky_clr);
	end

	// DMA done flags fire on the count's arrival at zero
	assign tx_reached = (tx_cnt_prev_r != '0) && (i_tx_dma_count == '0);
	assign rx_reached = (rx_cnt_prev_r != '0) && (i_rx_dma_count == '0);
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rst_n)
		begin
			tx_cnt_prev_r <= '0;
			rx_cnt_prev_r <= '0;
			tx_done_r <= 1'b0;
			rx_done_r <= 1'b0;
		end
		else
		begin
			tx_cnt_prev_r <= i_tx_dma_count;
			rx_cnt_prev_r <= i_rx_dma_count;
			// reaching zero sets, a count write clears
			tx_done_r <= tx_reached | (tx_done_r & ~i_tx_dma_count_wr);
			rx_done_r <= rx_reached | (rx_done_r & ~i_rx_dma_count_wr);
		end
	end

	// Interrupt enables: set register adds, clear register removes
	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rst_n)
			imr_r <= MASK_RESET;
		// ones set, zeros have no effect
		else if (wr_en && i_paddr == OFF_IRQ_SET)
			imr_r <= imr_r | i_pwdata[FLAG_W-1:0];
		else if (wr_en && i_paddr == OFF_IRQ_CLR)
			imr_r <= imr_r & ~i_pwdata[FLAG_W-1:0];
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (!i_rst_n)
			irq_r <= 1'b0;
		// any enabled flag raises the line
		else
			irq_r <= |(status_vec & imr_r);
	end
	assign o_irq = irq_r;

	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_n);

	hold_busy_a: assert property (
		wr_en && i_paddr == OFF_TX_HOLD |=> !status_vec[ST_TX_FREE])
		else $error("holding-free flag not cleared by write");
	tx_handover_a: assert property (
		tx_move && !(wr_en && i_paddr == OFF_TX_HOLD) |=> o_tx_word_load ##0 status_vec[ST_TX_FREE])
		else $error("word move did not free holding register");
	all_sent_a: assert property (
		status_vec[ST_TX_ALL_SENT] |-> !tx_full_r && !i_tx_shift_busy)
		else $error("all-sent while data remains");
	word_align_a: assert property (
		o_tx_word_load |-> (o_tx_word & ~$past(word_mask)) == '0)
		else $error("transmit word bits above length");
	bad_length_a: assert property (
		i_word_length_field == LEN_FORBIDDEN |=> !o_tx_word_load)
		else $error("word handed over at forbidden length");
	tx_done_a: assert property (
		tx_reached |=> tx_done_r ##0 status_vec[ST_TX_DMA_DONE])
		else $error("transmit dma done not set");
	tx_done_clr_a: assert property (
		i_tx_dma_count_wr && !tx_reached |=> !tx_done_r)
		else $error("transmit dma done not cleared by write");
	rx_done_a: assert property (
		rx_reached |=> rx_done_r)
		else $error("receive dma done not set");
	buf_flags_a: assert property (
		status_vec[ST_RX_BUF_FULL] == (i_rx_dma_count == '0 && i_rx_dma_next_count == '0))
		else $error("receive buffer full flag wrong");
	rx_avail_a: assert property (
		i_rx_word_load |=> rx_avail_r && rhr_r == ($past(i_rx_shift_word) & $past(word_mask)))
		else $error("received word not presented");
	rx_read_clr_a: assert property (
		rx_clear && !i_rx_word_load |=> !status_vec[ST_RX_AVAIL])
		else $error("receive-available not cleared by read");
	overrun_a: assert property (
		i_rx_word_load && rx_avail_r && !rhr_rd |=> sticky_r[ST_RX_OVERRUN])
		else $error("overrun not flagged");
	cmp_zero_a: assert property (
		i_rx_sync_load && i_rx_sync_shift == cmp0_r |=> status_vec[ST_CMP_ZERO])
		else $error("compare zero not flagged");
	cmp_one_a: assert property (
		i_rx_sync_load && i_rx_sync_shift == cmp1_r |=> status_vec[ST_CMP_ONE])
		else $error("compare one not flagged");
	tx_sync_a: assert property (
		$rose(pin_lvl_r[1]) && i_sync_edge_select == EDGE_RISE |=> sticky_r[ST_TX_SYNC])
		else $error("transmit sync edge lost");
	rx_sync_a: assert property (
		$fell(pin_lvl_r[2]) && i_rx_sync_edge_select == EDGE_FALL |=> sticky_r[ST_RX_SYNC])
		else $error("receive sync edge lost");
	status_clr_a: assert property (
		rd_en && i_paddr == OFF_STATUS && prdata_r[ST_TX_SYNC] && !tx_sync_evt
		|=> !sticky_r[ST_TX_SYNC])
		else $error("status read did not clear sync flag");
	enable_bits_a: assert property (
		setup_ph && !i_pwrite && i_paddr == OFF_STATUS
		|=> o_prdata[ST_TX_EN] == $past(i_tx_enabled_state))
		else $error("transmit enable not reported");
	irq_set_a: assert property (
		wr_en && i_paddr == OFF_IRQ_SET |=> (imr_r & $past(i_pwdata[FLAG_W-1:0])) == $past(i_pwdata[FLAG_W-1:0]) && (imr_r & $past(imr_r)) == $past(imr_r))
		else $error("enable write lost a source");
	irq_out_a: assert property (
		##1 o_irq == |($past(status_vec) & $past(imr_r)))
		else $error("interrupt output mismatch");
	sync_shift_a: assert property (
		link_fall && tx_fs_active && i_sync_data_enable && !tx_sync_evt
		|=> sync_shift_r == ($past(sync_shift_r) >> 1))
		else $error("sync word did not shift");

	tx_path_c: cover property (wr_en && i_paddr == OFF_TX_HOLD ##[1:40] o_tx_word_load);
	overrun_c: cover property (sticky_set[ST_RX_OVERRUN]);
	status_rd_c: cover property (rd_en && i_paddr == OFF_STATUS && prdata_r[ST_TX_SYNC]);
	irq_c: cover property (o_irq ##1 !o_irq);
endmodule : sync_serial_status_data_regs

/* testbench/serial_peer.sv */
`timescale 1ns/1ps
module serial_peer (
	output logic o_link_clk,
	output logic o_tx_fs,
	output logic o_rx_fs,
	input wire logic i_data_bit,
	input wire logic i_data_drive
);
	logic [15:0] got;
	logic drove;
	// Link clock stands high between frames, so the first falling edge is a real one
	initial
	begin
		o_link_clk = 1'b1;
		o_tx_fs = 1'b0;
		o_rx_fs = 1'b0;
		got = 16'h0000;
		drove = 1'b0;
	end
	// Both frame-sync pins move together, off the system clock edge
	task automatic set_sync(input logic lvl);
		#5;
		o_tx_fs = lvl;
		o_rx_fs = lvl;
	endtask : set_sync
	// Samples each bit late in the high phase, well after the sampled edge settles
	task automatic shift_out(input int n);
		drove = 1'b1;
		for (int k = 0; k < n; k++)
		begin
			#100;
			got[k] = i_data_bit;
			drove = drove & i_data_drive;
			o_link_clk = 1'b0;
			#100;
			o_link_clk = 1'b1;
		end
	endtask : shift_out
endmodule : serial_peer

/* testbench/sync_serial_status_data_regs_bench.sv */
`timescale 1ns/1ps
module sync_serial_status_data_regs_bench;
	import sync_serial_status_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, tx_word, rx_word = 32'h0, rd_v, w;
	logic pready, pslverr, link_clk, tx_fs, rx_fs, sd_bit, sd_drive, tx_load, irq, err_v;
	logic [LEN_W-1:0] len = 5'h07;
	logic edge_sel = 1'b0, rx_edge = 1'b0, sd_en = 1'b0, tx_en = 1'b1, rx_en = 1'b0;
	logic sh_ready = 1'b0, sh_busy = 1'b0, rx_load = 1'b0, rs_load = 1'b0;
	logic tx_wr = 1'b0, rx_wr = 1'b0;
	logic [15:0] rs_word = 16'h0, ts;
	logic [15:0] tx_cnt = 16'h3, tx_ncnt = 16'h3, rx_cnt = 16'h3, rx_ncnt = 16'h3;
	logic [15:0] cv [2];
	logic [31:0] tx_q [$], rx_q [$];
	int seed, k, mismatches = 0, n_checks = 0, cycles = 0;

	sync_serial_status_data_regs dut (
		.i_clk_sys(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_link_clk(link_clk),
		.i_tx_frame_sync(tx_fs), .i_rx_frame_sync(rx_fs), .o_sync_data_bit(sd_bit),
		.o_sync_data_drive(sd_drive), .i_word_length_field(len),
		.i_sync_edge_select(edge_sel), .i_rx_sync_edge_select(rx_edge),
		.i_sync_data_enable(sd_en), .i_tx_enabled_state(tx_en),
		.i_rx_enabled_state(rx_en), .i_tx_shift_ready(sh_ready),
		.i_tx_shift_busy(sh_busy), .o_tx_word(tx_word), .o_tx_word_load(tx_load),
		.i_rx_word_load(rx_load), .i_rx_shift_word(rx_word), .i_rx_sync_load(rs_load),
		.i_rx_sync_shift(rs_word), .i_tx_dma_count(tx_cnt),
		.i_tx_dma_next_count(tx_ncnt), .i_tx_dma_count_wr(tx_wr),
		.i_rx_dma_count(rx_cnt), .i_rx_dma_next_count(rx_ncnt),
		.i_rx_dma_count_wr(rx_wr), .o_irq(irq)
	);

	serial_peer peer (
		.o_link_clk(link_clk), .o_tx_fs(tx_fs), .o_rx_fs(rx_fs),
		.i_data_bit(sd_bit), .i_data_drive(sd_drive)
	);

	initial
	begin
		forever #12.5 clk = ~clk;
	end

	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : close_out

	// Whole run needs about five hundred cycles; the ceiling leaves wide margin
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			mismatches = mismatches + 1;
			close_out();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks = n_checks + 1;
		if (got !== exp)
		begin
			mismatches = mismatches + 1;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_bit(input logic got, input logic exp);
		n_checks = n_checks + 1;
		if (got !== exp)
		begin
			mismatches = mismatches + 1;
			$display("mismatch at %0t: level %b expected %b", $time, got, exp);
		end
	endtask : chk_bit

	// Model of the word length: the low length-plus-one bits carry data
	function automatic logic [31:0] len_mask(input logic [LEN_W-1:0] l);
		logic [31:0] m;
		m = 32'h0;
		for (int b = 0; b <= int'(l); b++)
			m[b] = 1'b1;
		return m;
	endfunction : len_mask

	// Request held until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd_v = prdata;
		err_v = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd_v & m, e);
	endtask : rdc

	// One-cycle strobe; its data was set by the caller an edge earlier
	task automatic pulse(input int sel);
		@(posedge clk);
		case (sel)
			0: rx_load <= 1'b1;
			1: rs_load <= 1'b1;
			2: tx_wr <= 1'b1;
			default: rx_wr <= 1'b1;
		endcase
		@(posedge clk);
		{rx_load, rs_load, tx_wr, rx_wr} <= 4'h0;
	endtask : pulse

	initial
	begin
		seed = 32'h11DE;
		rx_en = 1'($random(seed));
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		rdc(OFF_STATUS, 32'h0003_0FFF, {14'h0, rx_en, 1'b1, 16'h0003});
		rdc(OFF_IRQ_MASK, '1, 32'h0);
		rdc(OFF_TX_HOLD, '1, 32'h0);
		apb(1'b0, 8'h50, 32'h0);
		chk({err_v, rd_v[30:0]}, 32'h8000_0000);
		w = $random(seed);
		tx_q.push_back(w);
		apb(1'b1, OFF_TX_HOLD, w);
		rdc(OFF_STATUS, 32'h3, 32'h0);
		sh_ready <= 1'b1;
		do
			@(posedge clk);
		while (tx_load !== 1'b1);
		chk(tx_word, tx_q.pop_front() & len_mask(len));
		sh_ready <= 1'b0;
		sh_busy <= 1'b1;
		rdc(OFF_STATUS, 32'h3, 32'h1);
		sh_busy <= 1'b0;
		rdc(OFF_STATUS, 32'h3, 32'h3);
		// Forbidden length stalls the handover until a legal length returns
		len <= LEN_FORBIDDEN;
		w = $random(seed);
		tx_q.push_back(w);
		apb(1'b1, OFF_TX_HOLD, w);
		sh_ready <= 1'b1;
		repeat (4) @(posedge clk);
		rdc(OFF_STATUS, 32'h3, 32'h0);
		len <= 5'($random(seed)) | 5'h01;
		do
			@(posedge clk);
		while (tx_load !== 1'b1);
		chk(tx_word, tx_q.pop_front() & len_mask(len));
		sh_ready <= 1'b0;
		w = $random(seed);
		rx_word <= w;
		rx_q.push_back(w & len_mask(len));
		pulse(0);
		w = $random(seed);
		rx_word <= w;
		rx_q.push_back(w & len_mask(len));
		pulse(0);
		rdc(OFF_STATUS, 32'h30, (rx_q.size() > 1) ? 32'h30 : 32'h10);
		rdc(OFF_STATUS, 32'h20, 32'h0);
		rdc(OFF_RX_HOLD, '1, rx_q[$]);
		rx_q.delete();
		rdc(OFF_STATUS, 32'h10, 32'h0);
		cv[0] = 16'($random(seed)) | 16'h1;
		cv[1] = cv[0] ^ 16'h8000;
		for (k = 0; k < 2; k++)
		begin
			apb(1'b1, OFF_CMP_ZERO + ADDR_W'(4 * k), {16'hA5A5, cv[k]});
			rdc(OFF_CMP_ZERO + ADDR_W'(4 * k), '1, {16'h0, cv[k]});
		end
		for (k = 0; k < 2; k++)
		begin
			rs_word <= cv[k];
			pulse(1);
			rdc(OFF_RX_SYNC_HOLD, '1, {16'h0, cv[k]});
			rdc(OFF_STATUS, 32'h300, 32'h100 << k);
			rdc(OFF_STATUS, 32'h300, 32'h0);
		end
		rs_word <= cv[0];
		pulse(1);
		repeat (3) @(posedge clk);
		chk_bit(irq, 1'b0);
		apb(1'b1, OFF_IRQ_SET, 32'h100);
		repeat (2) @(posedge clk);
		chk_bit(irq, 1'b1);
		apb(1'b1, OFF_IRQ_SET, 32'h0);
		rdc(OFF_IRQ_MASK, '1, 32'h100);
		rdc(OFF_STATUS, 32'h100, 32'h100);
		repeat (2) @(posedge clk);
		chk_bit(irq, 1'b0);
		apb(1'b1, OFF_IRQ_CLR, 32'h100);
		rdc(OFF_IRQ_MASK, '1, 32'h0);
		{tx_cnt, tx_ncnt, rx_cnt, rx_ncnt} <= {16'h1, 16'h0, 16'h1, 16'h0};
		repeat (3) @(posedge clk);
		rdc(OFF_STATUS, 32'hCC, 32'h0);
		{tx_cnt, rx_cnt} <= 32'h0;
		repeat (3) @(posedge clk);
		rdc(OFF_STATUS, 32'hCC, 32'hCC);
		pulse(2);
		rdc(OFF_STATUS, 32'hCC, 32'hC8);
		pulse(3);
		rdc(OFF_STATUS, 32'hCC, 32'h88);
		sd_en <= 1'b1;
		for (k = 0; k < 2; k++)
		begin
			edge_sel <= k[0];
			rx_edge <= k[0];
			@(posedge clk);
			peer.set_sync(k[0]);
			ts = 16'($random(seed));
			apb(1'b1, OFF_TX_SYNC_HOLD, {16'h0, ts});
			rdc(OFF_TX_SYNC_HOLD, '1, {16'h0, ts});
			apb(1'b0, OFF_STATUS, 32'h0);
			peer.set_sync(~k[0]);
			repeat (10) @(posedge clk);
			rdc(OFF_STATUS, 32'hC00, 32'hC00);
			peer.shift_out(16);
			chk({16'h0, peer.got}, {16'h0, ts});
			chk_bit(peer.drove, 1'b1);
			peer.set_sync(k[0]);
			repeat (10) @(posedge clk);
			chk_bit(sd_drive, 1'b0);
			rdc(OFF_STATUS, 32'hC00, 32'h0);
		end
		close_out();
	end
endmodule : sync_serial_status_data_regs_bench
